// file: rtl/limit_bin_pkg.sv
// limit_bin_pkg: register map, field layouts, reset values and timing for the limit/binning block
// assumes a 125 MHz processing clock and readings as signed 32-bit fixed point in base units
package limit_bin_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NLINES = 4;

  // register offsets (word addresses, one word each)
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FIRST_LOW  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_FIRST_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_SECOND_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_SECOND_HIGH= 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PATTERNS   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_MANUAL     = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'h9;

  // control register fields
  localparam int unsigned CTRL_SET1_EN  = 0;
  localparam int unsigned CTRL_SET2_EN  = 1;
  localparam int unsigned CTRL_STROBE_EN= 2;
  localparam int unsigned CTRL_POL_LSB  = 4;   // 4 bits, 1 = active high

  // pattern register: nibbles for low1, high1, low2, high2, pass
  localparam int unsigned PAT_LOW1_LSB  = 0;
  localparam int unsigned PAT_HIGH1_LSB = 4;
  localparam int unsigned PAT_LOW2_LSB  = 8;
  localparam int unsigned PAT_HIGH2_LSB = 12;
  localparam int unsigned PAT_PASS_LSB  = 16;

  // status register fields
  localparam int unsigned ST_RESULT_LSB  = 0;  // 3 bits, result_t
  localparam int unsigned ST_SET1_BAD    = 3;
  localparam int unsigned ST_STATE_LSB   = 4;  // 4 bits, logical line states

  // interrupt events
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_FAIL = 1;
  localparam int unsigned NEV     = 2;

  // reset values; limits are Q16.16, so +1.0 is 0x0001_0000
  localparam logic [DATA_W-1:0] RST_FIRST_LOW = 32'h0001_0000;
  localparam logic [DATA_W-1:0] RST_LIMIT     = 32'h0000_0000;
  localparam logic [19:0]       RST_PATTERNS  = 20'h0_0000;
  localparam logic [3:0]        RST_POLARITY  = 4'hF;

  // strobe pulse: strictly longer than 10 us
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned STROBE_MIN_US  = 10;
  localparam int unsigned STROBE_CYCLES  = STROBE_MIN_US * CLK_MHZ + 1;
  localparam int unsigned STROBE_CNT_W   = 11;

  typedef enum logic [2:0] {
    RES_PASS  = 3'h0,
    RES_LOW1  = 3'h1,
    RES_HIGH1 = 3'h2,
    RES_LOW2  = 3'h3,
    RES_HIGH2 = 3'h4
  } result_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_PULSE  = 3'b010,
    ST_HOLD   = 3'b100
  } strobe_state_t;
endpackage

// file: rtl/limit_bin_top.sv
// limit_bin_top: limit tests, output patterns, binning strobe and register port
// assumes one reading-valid pulse per new reading, already past scale/offset and percent math
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// [RULE1] two independent limit sets, either or both
// [RULE2] limits stored unchecked, valid only if high>low
// [RULE3] reading compared in base units after math
// [RULE4] test order low1 high1 low2 high2
// [RULE5] all-pass drives programmed pass pattern
// [RULE6] each test owns a four-line pattern
// [RULE7] per-set enable gates output control
// [RULE8] first low defaults 1.0, patterns off
// [RULE9] strobe enable turns line four into strobe
// [RULE10] strobe true over 10 us after tests
// [RULE11] handler samples lines 1-3 on rising strobe
// [RULE12] enabling forces strobe false; disabling keeps level
// [RULE13] strobe mode ignores pattern bit four
// [RULE14] enabling control loads pass pattern immediately
// [RULE15] patterns logical; polarity sets physical level
// [RULE16] flag set one invalid when low>=high
// [RULE17] per-line polarity selectable, high or low
// [RULE18] manual state ignored while limits control
// [RULE19] strict compare; pattern held until next reading
module limit_bin_top
  import limit_bin_pkg::*;
(
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst,
  input  wire logic [limit_bin_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [limit_bin_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  input  wire logic [limit_bin_pkg::DATA_W-1:0] i_reading,
  input  wire logic                       i_reading_valid,
  output      logic [limit_bin_pkg::DATA_W-1:0] o_rdata,
  output      logic [limit_bin_pkg::NLINES-1:0] o_output_lines,
  output      logic                       o_set1_invalid,
  output      logic                       o_irq
);
  import limit_bin_pkg::*;

  logic [DATA_W-1:0]  first_low;
  logic [DATA_W-1:0]  first_high;
  logic [DATA_W-1:0]  second_low;
  logic [DATA_W-1:0]  second_high;
  logic               set1_en;
  logic               set2_en;
  logic               strobe_en;
  logic [NLINES-1:0]  polarity;
  logic [19:0]        patterns;
  logic [NLINES-1:0]  manual_state;
  logic [NLINES-1:0]  line_state;     // logical on/off of each line
  logic               strobe;
  logic [NEV-1:0]     irq_stat;
  logic [NEV-1:0]     irq_mask;
  result_t            last_result;
  strobe_state_t      sstate;
  logic [STROBE_CNT_W-1:0] scount;
  logic               tested;         // comparison done, strobe may start

  function automatic logic [NLINES-1:0] pick(input logic [19:0] p, input int unsigned lsb);
    pick = p[lsb +: NLINES];
  endfunction

  // register decode
  wire logic wr_ctrl   = i_wr && (i_addr == OFS_CTRL);
  wire logic wr_flow   = i_wr && (i_addr == OFS_FIRST_LOW);
  wire logic wr_fhigh  = i_wr && (i_addr == OFS_FIRST_HIGH);
  wire logic wr_slow   = i_wr && (i_addr == OFS_SECOND_LOW);
  wire logic wr_shigh  = i_wr && (i_addr == OFS_SECOND_HIGH);
  wire logic wr_pat    = i_wr && (i_addr == OFS_PATTERNS);
  wire logic wr_manual = i_wr && (i_addr == OFS_MANUAL);
  wire logic wr_istat  = i_wr && (i_addr == OFS_IRQ_STAT);
  wire logic wr_imask  = i_wr && (i_addr == OFS_IRQ_MASK);

  wire logic new_set1   = wr_ctrl ? i_wdata[CTRL_SET1_EN]   : set1_en;
  wire logic new_set2   = wr_ctrl ? i_wdata[CTRL_SET2_EN]   : set2_en;
  wire logic new_strobe = wr_ctrl ? i_wdata[CTRL_STROBE_EN] : strobe_en;

  wire logic limits_ctl  = set1_en || set2_en;                            // [RULE7]
  wire logic ctl_rise    = wr_ctrl && !limits_ctl && (new_set1 || new_set2); // [RULE14]
  wire logic strobe_rise = wr_ctrl && !strobe_en && new_strobe;            // [RULE12]
  wire logic strobe_fall = wr_ctrl && strobe_en && !new_strobe;            // [RULE12]

  result_t cmp_result;

  limit_compare u_compare (
    .i_reading     (i_reading),        // [RULE3]
    .i_first_low   (first_low),
    .i_first_high  (first_high),
    .i_second_low  (second_low),
    .i_second_high (second_high),
    .i_set1_en     (set1_en),          // [RULE1]
    .i_set2_en     (set2_en),
    .o_result      (cmp_result)
  );

  // pattern selected by the first failing test
  wire logic [NLINES-1:0] fail_pat =
      (cmp_result == RES_LOW1)  ? pick(patterns, PAT_LOW1_LSB)  :          // [RULE6]
      (cmp_result == RES_HIGH1) ? pick(patterns, PAT_HIGH1_LSB) :
      (cmp_result == RES_LOW2)  ? pick(patterns, PAT_LOW2_LSB)  :
      (cmp_result == RES_HIGH2) ? pick(patterns, PAT_HIGH2_LSB) :
                                  pick(patterns, PAT_PASS_LSB);           // [RULE5]

  // line four keeps its level when the strobe owns it
  wire logic [NLINES-1:0] eval_state =
      strobe_en ? {line_state[NLINES-1], fail_pat[NLINES-2:0]} : fail_pat; // [RULE13]

  wire logic [NLINES-1:0] pass_pat = pick(patterns, PAT_PASS_LSB);

  logic [NLINES-1:0] next_line_state;
  always_comb begin
    next_line_state = line_state;
    if (ctl_rise) begin
      next_line_state = pass_pat;                                         // [RULE14]
    end else if (limits_ctl && i_reading_valid) begin
      next_line_state = eval_state;                                       // [RULE19]
    end else if (!limits_ctl && wr_manual) begin
      next_line_state = i_wdata[NLINES-1:0];                              // [RULE18]
    end
    // disabling binning leaves line four where the strobe left it, not at the pattern bit
    if (strobe_fall && !ctl_rise) begin
      next_line_state[NLINES-1] = strobe;                                 // [RULE12]
    end
  end

  // strobe owns line four while enabled; the last strobe level persists after disable
  wire logic [NLINES-1:0] logic_lines =
      strobe_en ? {strobe, line_state[NLINES-2:0]} : line_state;          // [RULE9]

  wire logic set1_bad = ($signed(first_low) >= $signed(first_high));      // [RULE16]

  // strobe sequencer: wait for the compare to settle, then pulse
  logic next_strobe;
  strobe_state_t next_sstate;
  always_comb begin
    next_strobe = strobe;
    next_sstate = sstate;
    case (sstate)
      ST_IDLE: begin
        if (strobe_en && limits_ctl && tested) begin
          next_strobe = 1'b1;                                             // [RULE10]
          next_sstate = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (scount == STROBE_CNT_W'(STROBE_CYCLES - 1)) begin
          next_strobe = 1'b0;
          next_sstate = ST_IDLE;
        end
      end
      ST_HOLD: begin
        next_sstate = ST_IDLE;
      end
      default: begin
        next_sstate = ST_IDLE;
      end
    endcase
    if (strobe_rise || ctl_rise) begin
      next_strobe = 1'b0;                                                 // [RULE12] [RULE14]
      next_sstate = ST_IDLE;
    end else if (wr_ctrl && !new_strobe) begin
      next_sstate = ST_IDLE;                                              // [RULE12]
    end
  end

  wire logic [NEV-1:0] events = {
    limits_ctl && i_reading_valid && (cmp_result != RES_PASS),
    limits_ctl && i_reading_valid
  };
  wire logic [NEV-1:0] next_irq_stat =
      (irq_stat & ~(wr_istat ? i_wdata[NEV-1:0] : {NEV{1'b0}})) | events;

  wire logic [NLINES-1:0] poll_state = limits_ctl ? manual_state : line_state; // [RULE18]

  wire logic [DATA_W-1:0] next_rdata =
      (i_addr == OFS_CTRL)        ? {24'h00_0000, polarity, 1'b0, strobe_en, set2_en, set1_en} :
      (i_addr == OFS_FIRST_LOW)   ? first_low   :
      (i_addr == OFS_FIRST_HIGH)  ? first_high  :
      (i_addr == OFS_SECOND_LOW)  ? second_low  :
      (i_addr == OFS_SECOND_HIGH) ? second_high :
      (i_addr == OFS_PATTERNS)    ? {12'h000, patterns} :
      (i_addr == OFS_MANUAL)      ? {28'h000_0000, poll_state} :
      (i_addr == OFS_STATUS)      ? {24'h00_0000, line_state, set1_bad, last_result} :
      (i_addr == OFS_IRQ_STAT)    ? {30'h0000_0000, irq_stat} :
      (i_addr == OFS_IRQ_MASK)    ? {30'h0000_0000, irq_mask} : 32'h0000_0000;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      first_low   <= RST_FIRST_LOW;                                       // [RULE8]
      first_high  <= RST_LIMIT;
      second_low  <= RST_LIMIT;
      second_high <= RST_LIMIT;
      patterns    <= RST_PATTERNS;                                        // [RULE8]
      set1_en     <= 1'b0;
      set2_en     <= 1'b0;
      strobe_en   <= 1'b0;
      polarity    <= RST_POLARITY;
      irq_mask    <= {NEV{1'b0}};
    end else begin
      if (wr_flow)  first_low   <= i_wdata;                               // [RULE2]
      if (wr_fhigh) first_high  <= i_wdata;
      if (wr_slow)  second_low  <= i_wdata;
      if (wr_shigh) second_high <= i_wdata;
      if (wr_pat)   patterns    <= i_wdata[19:0];
      if (wr_ctrl) begin
        set1_en   <= new_set1;
        set2_en   <= new_set2;
        strobe_en <= new_strobe;
        polarity  <= i_wdata[CTRL_POL_LSB +: NLINES];                     // [RULE17]
      end
      if (wr_imask) irq_mask <= i_wdata[NEV-1:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      line_state   <= {NLINES{1'b0}};
      manual_state <= {NLINES{1'b0}};
      last_result  <= RES_PASS;
      tested       <= 1'b0;
      irq_stat     <= {NEV{1'b0}};
    end else begin
      line_state <= next_line_state;
      if (wr_manual) manual_state <= i_wdata[NLINES-1:0];
      if (limits_ctl && i_reading_valid) last_result <= cmp_result;
      // a new reading while a pulse is still out is tested but gets no extra pulse
      tested   <= limits_ctl && i_reading_valid && (sstate == ST_IDLE);
      irq_stat <= next_irq_stat;                                          // set wins over clear
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      strobe <= 1'b0;
      sstate <= ST_IDLE;
      scount <= {STROBE_CNT_W{1'b0}};
    end else begin
      strobe <= next_strobe;
      sstate <= next_sstate;
      scount <= (sstate == ST_PULSE) ? scount + 1'b1 : {STROBE_CNT_W{1'b0}};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata        <= {DATA_W{1'b0}};
      o_output_lines <= ~RST_POLARITY;
      o_set1_invalid <= 1'b0;
      o_irq          <= 1'b0;
    end else begin
      o_rdata        <= i_rd ? next_rdata : {DATA_W{1'b0}};
      o_output_lines <= ~(logic_lines ^ polarity);                        // [RULE15] [RULE17]
      o_set1_invalid <= set1_bad;                                         // [RULE16]
      o_irq          <= |(irq_stat & irq_mask);
    end
  end
endmodule // limit_bin_top

// file: rtl/limit_compare.sv
// limit_compare: four ordered limit tests on one reading, first failure wins
// assumes the reading is already scaled to base units and is signed
`timescale 1ns/1ps
module limit_compare
  import limit_bin_pkg::*;
(
  input  wire logic signed [DATA_W-1:0] i_reading,
  input  wire logic signed [DATA_W-1:0] i_first_low,
  input  wire logic signed [DATA_W-1:0] i_first_high,
  input  wire logic signed [DATA_W-1:0] i_second_low,
  input  wire logic signed [DATA_W-1:0] i_second_high,
  input  wire logic                     i_set1_en,
  input  wire logic                     i_set2_en,
  output      limit_bin_pkg::result_t   o_result
);
  wire logic fail_low1  = i_set1_en && (i_reading < i_first_low);   // [RULE19]
  wire logic fail_high1 = i_set1_en && (i_reading > i_first_high);  // [RULE19]
  wire logic fail_low2  = i_set2_en && (i_reading < i_second_low);  // [RULE19]
  wire logic fail_high2 = i_set2_en && (i_reading > i_second_high); // [RULE19]

  // fixed priority chain; no ordering check of low against high is made
  assign o_result = fail_low1  ? RES_LOW1  :                        // [RULE4] [RULE2]
                    fail_high1 ? RES_HIGH1 :
                    fail_low2  ? RES_LOW2  :
                    fail_high2 ? RES_HIGH2 : RES_PASS;              // [RULE5]
endmodule // limit_compare

// file: test/bin_handler.sv
// bin_handler: part-handler model that sorts on the rising strobe
// assumes it is told the line senses that the block is programmed with
`timescale 1ns/1ps
module bin_handler (
  input  wire logic        i_mclk,
  input  wire logic [3:0]  i_lines,
  input  wire logic [3:0]  i_polarity,
  output      logic [2:0]  o_bin,
  output      logic [15:0] o_count
);
  logic            strobe_prev = 1'b0;
  wire logic [3:0] logical = ~(i_lines ^ i_polarity);
  initial o_count = 16'h0;
  // only the false-to-true edge sorts a part; lines 1-3 are taken at that edge
  always @(posedge i_mclk) begin
    strobe_prev <= logical[3];
    if (logical[3] && !strobe_prev) begin
      o_bin   <= logical[2:0];
      o_count <= o_count + 16'h1;
    end
  end
endmodule // bin_handler

// file: test/limit_bin_monitor.sv
// limit_bin_monitor: port-level assertions for limit_bin_top
// assumes it is bound to limit_bin_top; it shadows control, pass pattern, set-one limits and mask
`timescale 1ns/1ps
module limit_bin_monitor
  import limit_bin_pkg::*;
(
  input wire logic                             i_mclk,
  input wire logic                             i_rst,
  input wire logic [limit_bin_pkg::ADDR_W-1:0] i_addr,
  input wire logic [limit_bin_pkg::DATA_W-1:0] i_wdata,
  input wire logic                             i_wr,
  input wire logic                             i_rd,
  input wire logic [limit_bin_pkg::DATA_W-1:0] i_reading,
  input wire logic                             i_reading_valid,
  input wire logic [limit_bin_pkg::DATA_W-1:0] o_rdata,
  input wire logic [limit_bin_pkg::NLINES-1:0] o_output_lines,
  input wire logic                             o_set1_invalid,
  input wire logic                             o_irq
);
  logic [7:0]         ctrl_sh;
  logic [3:0]         pass_sh;
  logic [1:0]         mask_sh;
  logic signed [31:0] lo1_sh;
  logic signed [31:0] hi1_sh;
  logic [10:0]        hi_cnt;
  wire logic          wr_ctrl  = i_wr && (i_addr == OFS_CTRL);
  wire logic          strobe_m = ctrl_sh[CTRL_STROBE_EN];
  wire logic          line4_on = (o_output_lines[3] == ctrl_sh[7]);
  wire logic          set1_bad = (lo1_sh >= hi1_sh);
  wire logic [3:0]    pass_on  = strobe_m ? {1'b0, pass_sh[2:0]} : pass_sh;
  wire logic [3:0]    pass_lvl = ~(pass_on ^ ctrl_sh[7:4]);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_sh <= 8'hF0;
      pass_sh <= 4'h0;
      mask_sh <= 2'h0;
      lo1_sh  <= RST_FIRST_LOW;
      hi1_sh  <= RST_LIMIT;
      hi_cnt  <= 11'h0;
    end else begin
      if (wr_ctrl) ctrl_sh <= i_wdata[7:0];
      if (i_wr && i_addr == OFS_PATTERNS) pass_sh <= i_wdata[19:16];
      if (i_wr && i_addr == OFS_IRQ_MASK) mask_sh <= i_wdata[1:0];
      if (i_wr && i_addr == OFS_FIRST_LOW) lo1_sh <= i_wdata;
      if (i_wr && i_addr == OFS_FIRST_HIGH) hi1_sh <= i_wdata;
      // counts logical-true cycles of line four; wraps harmlessly outside strobe mode
      hi_cnt <= line4_on ? hi_cnt + 11'h1 : 11'h0;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_strobe_rise;
    strobe_m && $stable(ctrl_sh) && $rose(line4_on);
  endsequence
  sequence s_strobe_arm;
    wr_ctrl && !strobe_m && i_wdata[CTRL_STROBE_EN];
  endsequence
  property p_strobe_len;
    strobe_m && $past(strobe_m, 2) && $stable(ctrl_sh) && $fell(line4_on) |->
      hi_cnt == STROBE_CYCLES;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
  property p_strobe_cause;
    s_strobe_rise |-> $past(i_reading_valid, 3);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without reading");
  property p_lines_settled;
    s_strobe_rise |-> $stable(o_output_lines[2:0]);
  endproperty
  a_lines_settled: assert property (p_lines_settled) else $error("bin lines moved");
  property p_strobe_arm;
    s_strobe_arm |-> ##2 !line4_on;
  endproperty
  a_strobe_arm: assert property (p_strobe_arm) else $error("strobe not forced");
  property p_strobe_keep;
    wr_ctrl && strobe_m && !i_wdata[CTRL_STROBE_EN] && ctrl_sh[1:0] != 2'h0 &&
      i_wdata[7:4] == ctrl_sh[7:4] |-> ##2 $stable(o_output_lines[3]);
  endproperty
  a_strobe_keep: assert property (p_strobe_keep) else $error("strobe level lost");
  property p_enable_pass;
    wr_ctrl && ctrl_sh[1:0] == 2'h0 && i_wdata[1:0] != 2'h0 |-> ##2 o_output_lines == pass_lvl;
  endproperty
  a_enable_pass: assert property (p_enable_pass) else $error("pass not loaded");
  property p_manual;
    i_wr && i_addr == OFS_MANUAL && ctrl_sh[1:0] != 2'h0 && !i_reading_valid &&
      !$past(i_reading_valid) |-> ##2 $stable(o_output_lines[2:0]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual write moved lines");
  property p_set1_inv;
    !$past(i_rst) |-> o_set1_invalid == $past(set1_bad);
  endproperty
  a_set1_inv: assert property (p_set1_inv) else $error("set one flag wrong");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_unmapped;
    i_rd && i_addr > OFS_IRQ_MASK |=> o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_masked;
    mask_sh == 2'h0 |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt seen");
endmodule // limit_bin_monitor

bind limit_bin_top limit_bin_monitor u_monitor (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_reading(i_reading), .i_reading_valid(i_reading_valid), .o_rdata(o_rdata),
  .o_output_lines(o_output_lines), .o_set1_invalid(o_set1_invalid), .o_irq(o_irq)
);

// file: test/limit_test_binning_outputs_tb.sv
// limit_test_binning_outputs_tb: self-checking bench for limit_bin_top
// assumes the monitor binds itself to the design and the handler model watches the lines
`timescale 1ns/1ps
module limit_test_binning_outputs_tb;
  import limit_bin_pkg::*;
  logic               i_mclk, i_rst, i_wr, i_rd, i_reading_valid;
  logic [ADDR_W-1:0]  i_addr;
  logic [DATA_W-1:0]  i_wdata, i_reading, o_rdata, patw;
  logic [NLINES-1:0]  o_output_lines;
  logic               o_set1_invalid, o_irq;
  logic [2:0]         hbin;
  logic [15:0]        hcount, hc;
  logic [7:0]         ctrl = 8'hF0;
  logic [3:0]         pat [5];
  logic [3:0]         e;
  logic signed [31:0] r;
  logic signed [31:0] lim [4];
  logic signed [31:0] tbl [10] = '{32'hFFFF_0000, 32'h0059_8000, 32'h005A_0000, 32'h006E_0000,
    32'h006E_8000, 32'h0063_0000, 32'h0062_FFFF, 32'h0065_0000, 32'h0065_0001, 32'h0064_0000};
  logic [2:0]         modes [4] = '{3'b011, 3'b001, 3'b010, 3'b111};
  logic [31:0]        rd_q [$], ln_q [$], msk, seed;
  logic               rd_d = 1'b0, vd1 = 1'b0, vd2 = 1'b0;
  int                 n_errors = 0, n_checks = 0, cyc = 0;
  limit_bin_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_reading(i_reading), .i_reading_valid(i_reading_valid),
    .o_rdata(o_rdata), .o_output_lines(o_output_lines), .o_set1_invalid(o_set1_invalid),
    .o_irq(o_irq));
  bin_handler u_handler (.i_mclk(i_mclk), .i_lines(o_output_lines), .i_polarity(ctrl[7:4]),
    .o_bin(hbin), .o_count(hcount));
  function automatic logic [3:0] on_of(input logic signed [31:0] rv);
    on_of = pat[4];
    if (ctrl[0] && rv < lim[0]) on_of = pat[0];
    else if (ctrl[0] && rv > lim[1]) on_of = pat[1];
    else if (ctrl[1] && rv < lim[2]) on_of = pat[2];
    else if (ctrl[1] && rv > lim[3]) on_of = pat[3];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    rd_q.push_back(exp);
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask
  task automatic set_ctrl(input logic [7:0] c);
    ctrl = c;
    wr(OFS_CTRL, {24'h0, c});
  endtask
  // in strobe mode line four belongs to the strobe, so only lines 1-3 are compared
  task automatic feed(input logic signed [31:0] rv);
    @(posedge i_mclk);
    i_reading_valid <= 1'b1;
    i_reading <= rv;
    ln_q.push_back({28'h0, ~(on_of(rv) ^ ctrl[7:4]) & (ctrl[2] ? 4'h7 : 4'hF)});
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  always @(posedge i_mclk) begin
    rd_d <= i_rd;
    vd1 <= i_reading_valid;
    vd2 <= vd1;
    if (rd_d === 1'b1) check(o_rdata, rd_q.pop_front());
    if (vd2 === 1'b1) begin
      msk = ctrl[2] ? 32'h7 : 32'hF;
      check({28'h0, o_output_lines} & msk, ln_q.pop_front());
    end
  end
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_reading = '0;
    i_reading_valid = 1'b0;
    seed = $urandom(84);
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(OFS_CTRL, 32'hF0);
    rd(OFS_FIRST_LOW, 32'h0001_0000);
    rd(OFS_PATTERNS, 32'h0);
    rd(OFS_STATUS, 32'h8);
    wr(4'hF, $urandom);
    rd(4'hF, 32'h0);
    lim = '{32'h005A_0000, 32'h006E_0000, 32'h0063_0000, 32'h0065_0000};
    for (int k = 0; k < 4; k++) begin
      pat[k] = {1'($urandom), 3'(k + 1)};
      wr(OFS_FIRST_LOW + 4'(k), lim[k]);
    end
    pat[4] = {1'($urandom), 3'h7};
    patw = {12'h0, pat[4], pat[3], pat[2], pat[1], pat[0]};
    wr(OFS_PATTERNS, patw);
    rd(OFS_PATTERNS, patw);
    for (int m = 0; m < 4; m++) begin
      set_ctrl({4'($urandom), 1'b0, modes[m][2], 2'h0});
      set_ctrl({ctrl[7:3], modes[m]});
      for (int i = 0; i < 12; i++) begin
        r = (i < 10) ? tbl[i] : 32'h0050_0000 + ($urandom % 32'h0028_0000);
        feed(r);
        if (ctrl[2]) begin
          e = on_of(r);
          hc = hcount;
          @(posedge i_mclk);
          i_reading_valid <= 1'b0;
          repeat (1300) @(posedge i_mclk);
          check({29'h0, hbin}, {29'h0, e[2:0]});
          check({16'h0, hcount}, {16'h0, hc + 16'h1});
        end
      end
      @(posedge i_mclk);
      i_reading_valid <= 1'b0;
      wr(OFS_MANUAL, $urandom);
    end
    lim[1] = lim[0];
    wr(OFS_FIRST_HIGH, lim[0]);
    repeat (3) @(posedge i_mclk);
    check({31'h0, o_set1_invalid}, 32'h1);
    rd(OFS_FIRST_HIGH, lim[0]);
    lim[1] = 32'h006E_0000;
    wr(OFS_FIRST_HIGH, lim[1]);
    set_ctrl({ctrl[7:4], 4'h1});
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STAT, 32'h3);
    feed(32'hFFFF_0000);
    @(posedge i_mclk);
    i_reading_valid <= 1'b0;
    repeat (3) @(posedge i_mclk);
    rd(OFS_STATUS, {24'h0, pat[0], 4'h1});
    rd(OFS_IRQ_STAT, 32'h3);
    check({31'h0, o_irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (3) @(posedge i_mclk);
    check({31'h0, o_irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h3);
    repeat (3) @(posedge i_mclk);
    check({31'h0, o_irq}, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    repeat (4) @(posedge i_mclk);
    end_sim();
  end
endmodule // limit_test_binning_outputs_tb
